/* File: design/pps_sequencer.sv */
// Purpose: Power sequencer for a line printer control system.
// Assumes: Button and supply-good inputs are synchronous and debounced.
// Notes: Runs with no cooperation from the processor it supervises.
`timescale 1ns/1ps

// Functional notes
// - Only this block drives the ON and OFF lamps and reads both buttons.
// - An ON press starts the cycle counter and turns the triac on.
// - Output port latches are held cleared throughout power-up.
// - The processor is held in reset with its start address at 0000 hex.
// - Power-ready rises only after the counter expires with all supplies good.
// - After power-ready the supplies and OFF button are watched continuously.
// - A supply loss or OFF press switches off the controller supply.
// - Shutdown lights OFF, darkens ON and returns to idle for the next ON.
// - Shutdown needs no action from the processor.
// - A power-down shows the printer off-line on the host run signal.
module pps_sequencer #(
  parameter int unsigned NUM_SUPPLY = 4,
  parameter int unsigned SETTLE_CYCLES = pps_pkg::SETTLE_CYC
) (
  input wire logic sys_clk, // system clock, 50 MHz
  input wire logic nrst, // synchronous reset, active low
  input wire pps_pkg::pps_btn_t btn, // operator ON and OFF buttons
  input wire logic [NUM_SUPPLY-1:0] supply_good, // per-rail good level
  output pps_pkg::pps_lamp_t lamp, // ON and OFF panel lamps
  output pps_pkg::pps_ctl_t ctl, // triac, supply, reset and ready
  output logic [15:0] reset_vector // start address during reset
);

  localparam int CW = $clog2(SETTLE_CYCLES + 1);
  localparam logic [CW-1:0] CNT_END = CW'(SETTLE_CYCLES);

  typedef struct packed {
    pps_pkg::pps_state_t st;
    logic [CW-1:0] cnt;
    pps_pkg::pps_lamp_t lamp;
    pps_pkg::pps_ctl_t ctl;
  } pps_reg_t;

  pps_reg_t s_q;
  pps_reg_t s_d;
  logic all_good;
  logic fault;

  assign all_good = &supply_good;
  // Faults use only local inputs, so a dead processor cannot block them.
  assign fault = !all_good || btn.off_btn;

  always_comb begin
    s_d = s_q;
    case (s_q.st)
      pps_pkg::PPS_IDLE: begin
        if (btn.on_btn && !btn.off_btn) begin
          s_d.st = pps_pkg::PPS_RAMP;
          s_d.cnt = '0;
          s_d.ctl.triac_on = 1'b1;
          s_d.ctl.ctl_supply_on = 1'b1;
          s_d.lamp.on_lamp = 1'b1;
          s_d.lamp.off_lamp = 1'b0;
        end
      end
      pps_pkg::PPS_RAMP: begin
        if (btn.off_btn) begin
          s_d.st = pps_pkg::PPS_DOWN;
        end else if (s_q.cnt != CNT_END) begin
          s_d.cnt = s_q.cnt + CW'(1);
        end else if (all_good) begin
          s_d.st = pps_pkg::PPS_RUN;
          s_d.ctl.power_ready = 1'b1;
          s_d.ctl.cpu_reset = 1'b0;
          s_d.ctl.out_clear = 1'b0;
          s_d.ctl.host_online = 1'b1;
        end
      end
      pps_pkg::PPS_RUN: begin
        if (fault) begin
          s_d.st = pps_pkg::PPS_DOWN;
          s_d.ctl.power_ready = 1'b0;
          s_d.ctl.cpu_reset = 1'b1;
          s_d.ctl.out_clear = 1'b1;
          s_d.ctl.host_online = 1'b0;
          s_d.ctl.ctl_supply_on = 1'b0;
        end
      end
      pps_pkg::PPS_DOWN: begin
        s_d.st = pps_pkg::PPS_IDLE;
      end
      default: begin
        s_d.st = pps_pkg::PPS_IDLE;
      end
    endcase
    if (s_d.st == pps_pkg::PPS_DOWN) begin
      s_d.ctl.power_ready = 1'b0;
      s_d.ctl.cpu_reset = 1'b1;
      s_d.ctl.out_clear = 1'b1;
      s_d.ctl.host_online = 1'b0;
      s_d.ctl.ctl_supply_on = 1'b0;
      s_d.ctl.triac_on = 1'b0;
      s_d.lamp.on_lamp = 1'b0;
      s_d.lamp.off_lamp = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      s_q.st <= pps_pkg::PPS_IDLE;
      s_q.cnt <= '0;
      s_q.lamp <= pps_pkg::LAMP_OFF;
      s_q.ctl <= pps_pkg::CTL_OFF;
    end else begin
      s_q <= s_d;
    end
  end

  assign lamp = s_q.lamp;
  assign ctl = s_q.ctl;
  // The processor fetches from the reset vector whenever reset lifts.
  assign reset_vector = pps_pkg::RESET_VECTOR;

  // Power-up: reset and cleared ports throughout ramp.
  chk_ramp_holds_reset: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    s_q.st == pps_pkg::PPS_RAMP |-> ctl.cpu_reset && ctl.out_clear
      && !ctl.power_ready)
    else $error("ramp without reset or port clear");

  chk_reset_vector: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    ctl.cpu_reset |-> reset_vector == 16'h0000)
    else $error("reset vector not zero");

  chk_on_starts: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    s_q.st == pps_pkg::PPS_IDLE && btn.on_btn && !btn.off_btn
      |=> ctl.triac_on && s_q.cnt == '0 && lamp.on_lamp)
    else $error("on press did not start power-up");

  chk_ready_cause: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    $rose(ctl.power_ready) |-> $past(s_q.cnt) == CNT_END
      && $past(all_good))
    else $error("ready without counter expiry and good supplies");

  sequence run_fault_s;
    s_q.st == pps_pkg::PPS_RUN && fault;
  endsequence

  chk_fault_drops: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    run_fault_s |=> !ctl.ctl_supply_on && !ctl.power_ready
      && ctl.cpu_reset)
    else $error("fault did not shut down");

  chk_shutdown_idle: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    run_fault_s |=> lamp.off_lamp && !lamp.on_lamp
      ##1 s_q.st == pps_pkg::PPS_IDLE)
    else $error("shutdown did not return to idle");

  chk_offline: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    ctl.host_online |-> ctl.power_ready && s_q.st == pps_pkg::PPS_RUN)
    else $error("online while not powered");

  chk_run_monitor: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    ctl.power_ready && $past(ctl.power_ready) |-> $past(all_good)
      && !$past(btn.off_btn))
    else $error("ready held across a fault");

  chk_lamps_exclusive: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    lamp.on_lamp != lamp.off_lamp)
    else $error("lamps not complementary");

  sequence idle_press_s;
    s_q.st == pps_pkg::PPS_IDLE && btn.on_btn && !btn.off_btn;
  endsequence

  sequence ramp_abort_s;
    s_q.st == pps_pkg::PPS_RAMP && btn.off_btn;
  endsequence

  sequence ramp_expire_s;
    s_q.st == pps_pkg::PPS_RAMP && !btn.off_btn && s_q.cnt == CNT_END;
  endsequence

  sequence down_state_s;
    s_q.st == pps_pkg::PPS_DOWN;
  endsequence

  // Every output in its safe level, as after reset.
  sequence shut_outputs_s;
    !ctl.triac_on && !ctl.ctl_supply_on && !ctl.power_ready
      && ctl.cpu_reset && ctl.out_clear && !ctl.host_online
      && lamp.off_lamp && !lamp.on_lamp;
  endsequence

  chk_press_enters_ramp: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    idle_press_s |=> s_q.st == pps_pkg::PPS_RAMP && ctl.ctl_supply_on
      && !lamp.off_lamp)
    else $error("on press did not enter ramp");

  chk_triac_cause: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    $rose(ctl.triac_on) |-> $past(s_q.st) == pps_pkg::PPS_IDLE
      && $past(btn.on_btn) && !$past(btn.off_btn))
    else $error("triac closed without an on press");

  chk_ramp_counts: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    s_q.st == pps_pkg::PPS_RAMP && !btn.off_btn && s_q.cnt != CNT_END
      |=> s_q.st == pps_pkg::PPS_RAMP && s_q.cnt == $past(s_q.cnt) + CW'(1))
    else $error("ramp counter did not advance");

  chk_ramp_waits: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    ramp_expire_s ##0 !all_good |=> s_q.st == pps_pkg::PPS_RAMP
      && s_q.cnt == CNT_END && !ctl.power_ready)
    else $error("ready rose with a supply still bad");

  chk_ramp_release: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    ramp_expire_s ##0 all_good |=> ctl.power_ready && !ctl.cpu_reset
      && !ctl.out_clear && ctl.host_online)
    else $error("expired ramp with good supplies did not run");

  chk_ready_only_run: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    ctl.power_ready |-> s_q.st == pps_pkg::PPS_RUN)
    else $error("ready outside the run state");

  chk_reset_ready_pair: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    ctl.cpu_reset != ctl.power_ready)
    else $error("reset and ready not complementary");

  chk_clear_with_reset: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    ctl.out_clear == ctl.cpu_reset)
    else $error("port clear not tied to processor reset");

  chk_triac_with_supply: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    ctl.triac_on == ctl.ctl_supply_on)
    else $error("triac and controller supply disagree");

  chk_lamp_with_triac: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    lamp.on_lamp == ctl.triac_on)
    else $error("on lamp does not follow the triac");

  chk_run_holds: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    s_q.st == pps_pkg::PPS_RUN && !fault |=> s_q.st == pps_pkg::PPS_RUN
      && ctl.power_ready && lamp.on_lamp)
    else $error("run left without a fault");

  chk_fault_to_down: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    run_fault_s |=> down_state_s)
    else $error("fault did not reach the shutdown state");

  chk_ramp_abort: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    ramp_abort_s |=> shut_outputs_s ##1 s_q.st == pps_pkg::PPS_IDLE)
    else $error("off press did not abort power-up");

  chk_down_to_idle: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    down_state_s |-> shut_outputs_s ##1 s_q.st == pps_pkg::PPS_IDLE)
    else $error("shutdown state did not settle in idle");

  chk_idle_quiet: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    s_q.st == pps_pkg::PPS_IDLE |-> shut_outputs_s)
    else $error("idle with an output still driven");

  chk_refused_press: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    s_q.st == pps_pkg::PPS_IDLE && btn.on_btn && btn.off_btn
      |=> s_q.st == pps_pkg::PPS_IDLE && !ctl.triac_on)
    else $error("power-up started with off held");

  chk_host_drops: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    $fell(ctl.power_ready) |-> !ctl.host_online
      && s_q.st == pps_pkg::PPS_DOWN)
    else $error("host still sees the printer online");

  chk_run_outputs: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    s_q.st == pps_pkg::PPS_RUN |-> ctl.triac_on && ctl.ctl_supply_on
      && !ctl.cpu_reset && !ctl.out_clear)
    else $error("run state without power or with reset");

  chk_run_vector: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    $fell(ctl.cpu_reset) |-> reset_vector == pps_pkg::RESET_VECTOR
      && $past(s_q.st) == pps_pkg::PPS_RAMP)
    else $error("reset lifted outside a completed ramp");

  // One check per rail, so a loss on any single rail is covered.
  for (genvar g = 0; g < NUM_SUPPLY; g++) begin : g_rail
    chk_rail_loss: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      s_q.st == pps_pkg::PPS_RUN && !supply_good[g]
        |=> !ctl.ctl_supply_on && !ctl.power_ready)
      else $error("rail loss did not stop the supply");
  end

endmodule

/* File: design/pps_pkg.sv */
// Purpose: Shared constants and types for the printer power sequencer.
// Assumes: One 50 MHz clock, synchronous active-low reset.
// Notes: Supply health arrives as a vector of good levels.
package pps_pkg;

  localparam int unsigned CLK_HZ = 50_000_000;
  // Power-up settle time in microseconds before power-ready may rise.
  localparam int unsigned SETTLE_US = 100_000;
  localparam int unsigned SETTLE_CYC = SETTLE_US * (CLK_HZ / 1_000_000);
  localparam logic [15:0] RESET_VECTOR = 16'h0000;

  typedef enum logic [3:0] {
    PPS_IDLE = 4'b0001,
    PPS_RAMP = 4'b0010,
    PPS_RUN = 4'b0100,
    PPS_DOWN = 4'b1000
  } pps_state_t;

  // Operator panel: buttons in, lamps out.
  typedef struct packed {
    logic on_btn;
    logic off_btn;
  } pps_btn_t;

  typedef struct packed {
    logic on_lamp;
    logic off_lamp;
  } pps_lamp_t;

  // Controls toward the processor side of the printer.
  typedef struct packed {
    logic triac_on;
    logic ctl_supply_on;
    logic out_clear;
    logic cpu_reset;
    logic power_ready;
    logic host_online;
  } pps_ctl_t;

  // Safe levels held in reset and after every shutdown.
  localparam pps_lamp_t LAMP_OFF = '{on_lamp: 1'h0, off_lamp: 1'h1};
  localparam pps_ctl_t CTL_OFF = '{triac_on: 1'h0, ctl_supply_on: 1'h0,
    out_clear: 1'h1, cpu_reset: 1'h1, power_ready: 1'h0, host_online: 1'h0};

endpackage

/* File: tb/pps_supply_model.sv */
// Purpose: Supply monitors behind the triac, seen by the sequencer.
// Assumes: Rails come up a set number of cycles after the triac closes.
// Notes: A set bit of fail_mask holds that rail low, to model a loss.
`timescale 1ns/1ps
module pps_supply_model (
  input wire logic sys_clk, // system clock
  input wire logic triac_on, // transformer triac from the sequencer
  input wire logic [3:0] fail_mask, // rails forced bad
  input wire logic [7:0] up_delay, // cycles until rails are good
  output logic [3:0] supply_good // per-rail good level
);
  logic [7:0] up_q;
  always_ff @(posedge sys_clk) begin
    up_q <= !triac_on ? 8'h00 : (up_q == 8'hff ? up_q : up_q + 8'h01);
  end
  // Rails read bad while the transformer is off, as a real monitor would.
  assign supply_good = (triac_on && up_q >= up_delay) ? ~fail_mask : 4'h0;
endmodule

/* File: tb/tb_pps_sequencer.sv */
// Purpose: Self-checking bench for the printer power sequencer.
// Assumes: Short settle count so a power-up takes a few cycles.
// Notes: Expected output changes are queued and matched in order.
`timescale 1ns/1ps
module tb_pps_sequencer;
  localparam int unsigned SC = 8;
  localparam logic [7:0] RAMP_V = 8'hbc;
  localparam logic [7:0] RUN_V = 8'hb3;
  localparam logic [7:0] DOWN_V = 8'h4c;
  logic sys_clk = 1'h0;
  logic nrst = 1'h0;
  pps_pkg::pps_btn_t btn = '0;
  logic [3:0] supply_good;
  logic [3:0] fail_mask = 4'h0;
  logic [7:0] up_delay = 8'h00;
  pps_pkg::pps_lamp_t lamp;
  pps_pkg::pps_ctl_t ctl;
  logic [15:0] reset_vector;
  int bad_count = 0;
  int check_count = 0;
  int hung = 0;
  int seed = 32'h476d_4bce;
  logic [7:0] exp_q[$];
  logic [7:0] prev_v = DOWN_V;
  always #10 sys_clk = ~sys_clk;
  pps_sequencer #(.NUM_SUPPLY(4), .SETTLE_CYCLES(SC)) i_dut (
    .sys_clk(sys_clk), .nrst(nrst), .btn(btn), .supply_good(supply_good),
    .lamp(lamp), .ctl(ctl), .reset_vector(reset_vector));
  pps_supply_model i_sup (.sys_clk(sys_clk), .triac_on(ctl.triac_on),
    .fail_mask(fail_mask), .up_delay(up_delay), .supply_good(supply_good));
  task conclude();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task check(input logic [15:0] got, input logic [15:0] exp, string what);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
    end
  endtask
  // A change with nothing queued is a spurious output move.
  always @(negedge sys_clk) begin
    if (nrst && {lamp, ctl} !== prev_v) begin
      if (exp_q.size() == 0)
        check({8'h00, lamp, ctl}, {8'h00, prev_v}, "stray");
      else
        check({8'h00, lamp, ctl}, {8'h00, exp_q.pop_front()}, "outs");
    end
    prev_v = {lamp, ctl};
  end
  task run_case(input int mode);
    int rail;
    int n;
    int want;
    rail = $unsigned($random(seed)) % 4;
    up_delay = 8'($unsigned($random(seed)) % 16);
    exp_q.push_back(RAMP_V);
    btn.on_btn = 1'h1;
    @(negedge sys_clk) btn.on_btn = 1'h0;
    check(reset_vector, 16'h0000, "vector");
    if (mode == 2) begin
      exp_q.push_back(DOWN_V);
      btn.off_btn = 1'h1;
    end else begin
      exp_q.push_back(RUN_V);
      n = 0;
      while (ctl.power_ready !== 1'h1 && n < 200) begin
        @(negedge sys_clk);
        n++;
      end
      if (n >= 200) begin
        check(16'h0000, 16'h0001, "timeout");
        hung = 1;
        return;
      end
      // Ready follows the later of counter expiry and the slowest rail.
      want = (up_delay > SC) ? up_delay + 1 : SC + 1;
      check(16'(n), 16'(want), "ready cycle");
      btn.on_btn = 1'h1;
      @(negedge sys_clk) btn.on_btn = 1'h0;
      exp_q.push_back(DOWN_V);
      if (mode == 0)
        btn.off_btn = 1'h1;
      else
        fail_mask[rail] = 1'h1;
    end
    @(negedge sys_clk) btn.off_btn = 1'h0;
    check({13'h0, ctl.power_ready, ctl.cpu_reset, ctl.host_online},
      16'h0002, "down");
    fail_mask = 4'h0;
    repeat (3) @(negedge sys_clk);
    check(16'(exp_q.size()), 16'h0000, "missing");
    $display("case mode %0d done", mode);
  endtask
  initial begin
    repeat (20) @(negedge sys_clk);
    check({8'h00, lamp, ctl}, {8'h00, DOWN_V}, "reset");
    nrst = 1'h1;
    // Both buttons at once must leave the outputs still.
    btn = '1;
    @(negedge sys_clk) btn = '0;
    @(negedge sys_clk);
    for (int i = 0; i < 9 && hung == 0; i++) begin
      run_case(i % 3);
    end
    conclude();
  end
endmodule
